// ==== rtl/fcp_pkg.sv ====
package fcp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned FCP_DATA_W = 36;  // Port word width
  localparam int unsigned FCP_DEPTH_LOG2 = 14;  // Default depth 16K words
  localparam int unsigned FCP_BYTE_W = 9;  // Narrow byte lane
  localparam int unsigned FCP_HALF_W = 18;  // Narrow word lane
  localparam int unsigned FCP_IP_SKIP_BIT = 8;  // Parity bit skipped in interleaved load
  localparam int unsigned FCP_IP_HIGH_LSB = 9;  // First upper bit used in interleaved load

  // ----------------------------------------------------------------
  // Start-up timing (cycles of i_sys_clk)
  // ----------------------------------------------------------------
  localparam logic [2:0] FCP_SYNC_STAGES = 3'h2;  // Pin synchroniser depth
  localparam logic [2:0] FCP_IR_DELAY = 3'h2;  // Write cycles until ready
  localparam logic [2:0] FCP_CAPTURE_CYCLE = FCP_SYNC_STAGES;
  localparam logic [2:0] FCP_RUN_CYCLE = FCP_SYNC_STAGES + FCP_IR_DELAY;

  // ----------------------------------------------------------------
  // Flag select patterns {sel2, sel1, sel0} and preset offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] FCP_FS_P64 = 3'h7;
  localparam logic [2:0] FCP_FS_P16 = 3'h6;
  localparam logic [2:0] FCP_FS_P8 = 3'h5;
  localparam logic [2:0] FCP_FS_P256 = 3'h3;
  localparam logic [2:0] FCP_FS_P1024 = 3'h1;
  localparam logic [2:0] FCP_FS_SERIAL = 3'h2;
  localparam logic [2:0] FCP_FS_PARALLEL = 3'h4;
  localparam logic [2:0] FCP_FS_PAR_IP = 3'h0;
  localparam logic [15:0] FCP_PRESET_64 = 16'h0040;
  localparam logic [15:0] FCP_PRESET_16 = 16'h0010;
  localparam logic [15:0] FCP_PRESET_8 = 16'h0008;
  localparam logic [15:0] FCP_PRESET_256 = 16'h0100;
  localparam logic [15:0] FCP_PRESET_1024 = 16'h0400;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FCP_LOAD_PRESET = 2'b00,
    FCP_LOAD_SERIAL = 2'b01,
    FCP_LOAD_PARALLEL = 2'b10,
    FCP_LOAD_PAR_IP = 2'b11
  } fcp_load_mode_t;

  typedef enum logic [1:0] {
    FCP_BUS_LONG = 2'b00,
    FCP_BUS_WORD = 2'b01,
    FCP_BUS_BYTE = 2'b10
  } fcp_bus_size_t;

  // All pin inputs, carried together through the synchroniser
  typedef struct packed {
    logic endian_mode_select;
    logic flag_sel2;
    logic flag_sel1_serial_enable_n;
    logic flag_sel0_serial_in;
    logic [1:0] read_bus_size;
    logic write_port_select_n;
    logic write_port_direction;
    logic write_port_enable;
    logic write_port_mailbox_sel;
    logic read_port_select_n;
    logic read_port_direction;
    logic read_port_enable;
    logic read_port_mailbox_sel;
    logic [FCP_DATA_W-1:0] write_port_data;
  } fcp_pins_t;

endpackage : fcp_pkg

// ==== rtl/fcp_ofs_if.sv ====
`timescale 1ns/1ps
// Offset loader link between the port logic and the offset unit
interface fcp_ofs_if #(
  parameter int unsigned OFS_W = 14
);
  import fcp_pkg::*;
  logic capture;  // One-cycle pulse: latch load mode now
  fcp_load_mode_t mode;  // Load mode decoded from flag selects
  logic [OFS_W-1:0] preset;  // Preset offset for preset mode
  logic par_wr;  // Accepted write offered to the offset unit
  logic [FCP_DATA_W-1:0] par_data;  // Write word for parallel load
  logic ser_bit;  // Serial data bit
  logic ser_en_n;  // Serial shift enable, active low
  logic absorb;  // Unit takes this write, memory must not
  logic done;  // Both offsets loaded
  logic [OFS_W-1:0] x_ofs;  // Almost-empty offset
  logic [OFS_W-1:0] y_ofs;  // Almost-full offset

  modport port (
    output capture, mode, preset, par_wr, par_data, ser_bit, ser_en_n,
    input absorb, done, x_ofs, y_ofs
  );
  modport unit (
    input capture, mode, preset, par_wr, par_data, ser_bit, ser_en_n,
    output absorb, done, x_ofs, y_ofs
  );
endinterface : fcp_ofs_if

// ==== rtl/fcp_offset_unit.sv ====
`timescale 1ns/1ps
module fcp_offset_unit
  import fcp_pkg::*;
#(
  parameter int unsigned OFS_W = 14
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Offset link
  fcp_ofs_if.unit ofs
);

  // ----------------------------------------------------------------
  // Load sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FCP_OS_WAIT = 2'b00,  // Waiting for mode capture
    FCP_OS_Y = 2'b01,  // Next load goes to Y
    FCP_OS_X = 2'b10,  // Next load goes to X
    FCP_OS_DONE = 2'b11  // Offsets complete
  } fcp_ofs_state_t;

  localparam int unsigned BIT_CNT_W = $clog2(2 * OFS_W + 1);
  localparam logic [BIT_CNT_W-1:0] LAST_Y_BIT = BIT_CNT_W'(OFS_W - 1);
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(2 * OFS_W - 1);

  fcp_ofs_state_t state_ff, nxt_state;  // Sequencer state
  fcp_load_mode_t mode_ff;  // Latched load mode
  logic [BIT_CNT_W-1:0] bit_cnt_ff;  // Serial bits taken so far
  logic [OFS_W-1:0] x_ff;  // Almost-empty offset
  logic [OFS_W-1:0] y_ff;  // Almost-full offset
  wire logic loading = (state_ff == FCP_OS_Y) || (state_ff == FCP_OS_X);
  wire logic par_mode = (mode_ff == FCP_LOAD_PARALLEL) || (mode_ff == FCP_LOAD_PAR_IP);
  wire logic ser_mode = (mode_ff == FCP_LOAD_SERIAL);
  // Serial bit taken while enable is low
  wire logic ser_take = loading && ser_mode && !ofs.ser_en_n;
  wire logic par_take = loading && par_mode && ofs.par_wr;
  wire logic [OFS_W-1:0] par_plain = ofs.par_data[OFS_W-1:0];
  wire logic [OFS_W-1:0] par_ip = {ofs.par_data[OFS_W:FCP_IP_HIGH_LSB],
                                   ofs.par_data[FCP_IP_SKIP_BIT-1:0]};
  wire logic [OFS_W-1:0] par_val = (mode_ff == FCP_LOAD_PAR_IP) ? par_ip : par_plain;
  wire logic ser_last = ser_take && (bit_cnt_ff == LAST_BIT);

  assign ofs.absorb = par_take;
  assign ofs.done = (state_ff == FCP_OS_DONE);
  assign ofs.x_ofs = x_ff;
  assign ofs.y_ofs = y_ff;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FCP_OS_WAIT: begin
        if (ofs.capture) begin
          nxt_state = (ofs.mode == FCP_LOAD_PRESET) ? FCP_OS_DONE : FCP_OS_Y;
        end
      end
      FCP_OS_Y: begin
        if (par_take || (ser_take && bit_cnt_ff == LAST_Y_BIT)) begin
          nxt_state = FCP_OS_X;
        end
      end
      FCP_OS_X: begin
        if (par_take || ser_last) begin
          nxt_state = FCP_OS_DONE;
        end
      end
      FCP_OS_DONE: nxt_state = FCP_OS_DONE;
      default: nxt_state = FCP_OS_WAIT;
    endcase
  end

  // State and mode registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= FCP_OS_WAIT;
      mode_ff <= FCP_LOAD_PRESET;
    end else begin
      state_ff <= nxt_state;
      if (ofs.capture) begin
        mode_ff <= ofs.mode;
      end
    end
  end

  // Serial bit counter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_ff <= '0;
    end else if (ser_take) begin
      bit_cnt_ff <= bit_cnt_ff + BIT_CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      x_ff <= '0;
      y_ff <= '0;
    end else if (ofs.capture && ofs.mode == FCP_LOAD_PRESET) begin
      x_ff <= ofs.preset;
      y_ff <= ofs.preset;
    end else if (par_take && state_ff == FCP_OS_Y) begin
      y_ff <= par_val;
    end else if (par_take) begin
      x_ff <= par_val;
    end else if (ser_take && state_ff == FCP_OS_Y) begin
      y_ff <= {y_ff[OFS_W-2:0], ofs.ser_bit};
    end else if (ser_take) begin
      x_ff <= {x_ff[OFS_W-2:0], ofs.ser_bit};
    end
  end

endmodule // fcp_offset_unit

// ==== rtl/fcp_port_access.sv ====
`timescale 1ns/1ps
module fcp_port_access
  import fcp_pkg::*;
#(
  parameter int unsigned DEPTH_LOG2 = FCP_DEPTH_LOG2
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Configuration pins
  input wire logic i_endian_mode_select,
  input wire logic i_flag_sel2,
  input wire logic i_flag_sel1_serial_enable_n,
  input wire logic i_flag_sel0_serial_in,
  input wire logic [1:0] i_read_bus_size,
  // Write port
  input wire logic i_write_port_select_n,
  input wire logic i_write_port_direction,
  input wire logic i_write_port_enable,
  input wire logic i_write_port_mailbox_sel,
  input wire logic [FCP_DATA_W-1:0] i_write_port_data,
  output logic [FCP_DATA_W-1:0] o_write_port_data,
  output logic o_write_port_data_oe,
  // Read port
  input wire logic i_read_port_select_n,
  input wire logic i_read_port_direction,
  input wire logic i_read_port_enable,
  input wire logic i_read_port_mailbox_sel,
  output logic [FCP_DATA_W-1:0] o_read_port_data,
  output logic o_read_port_data_oe,
  // Flags
  output logic o_full_input_ready,
  output logic o_empty_output_ready,
  output logic o_almost_empty_n,
  output logic o_almost_full_n,
  // Latched configuration
  output logic o_byte_order_select,
  output logic o_fallthrough_mode,
  output logic o_interleaved_parity_mode,
  output logic o_config_done
);

  // ----------------------------------------------------------------
  // Parameters and local types
  // ----------------------------------------------------------------
  localparam int unsigned DEPTH = 1 << DEPTH_LOG2;
  localparam int unsigned CNT_W = DEPTH_LOG2 + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  // Refuse depths that the offset widths cannot serve
  if (DEPTH_LOG2 < 11 || DEPTH_LOG2 > 16) begin : g_bad_depth
    $error("DEPTH_LOG2 must lie in 11..16");
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  fcp_pins_t pin_raw;  // Raw pins
  fcp_pins_t sync1_ff;  // First stage, read only by sync2_ff
  fcp_pins_t sync2_ff;  // Settled pins

  assign pin_raw = '{
    endian_mode_select: i_endian_mode_select,
    flag_sel2: i_flag_sel2,
    flag_sel1_serial_enable_n: i_flag_sel1_serial_enable_n,
    flag_sel0_serial_in: i_flag_sel0_serial_in,
    read_bus_size: i_read_bus_size,
    write_port_select_n: i_write_port_select_n,
    write_port_direction: i_write_port_direction,
    write_port_enable: i_write_port_enable,
    write_port_mailbox_sel: i_write_port_mailbox_sel,
    read_port_select_n: i_read_port_select_n,
    read_port_direction: i_read_port_direction,
    read_port_enable: i_read_port_enable,
    read_port_mailbox_sel: i_read_port_mailbox_sel,
    write_port_data: i_write_port_data
  };

  // Two flops before any logic except the data output enables, which use the raw pins
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequence and configuration latch
  // ----------------------------------------------------------------
  logic [2:0] start_cnt_ff;  // Cycles since reset release
  logic cfg_done_ff;  // Configuration captured
  logic run_ff;  // Start-up delay over
  logic byte_order_ff;  // High: most significant lane first
  logic fallthrough_mode_ff;  // High: fall-through timing
  logic ip_ff;  // Interleaved parity chosen
  logic par_ff;  // Plain parallel load chosen, latched so FS2 may change later
  fcp_load_mode_t load_mode;  // Decoded load mode
  logic [DEPTH_LOG2-1:0] preset_val;  // Decoded preset offset
  wire logic [2:0] fs_pat = {sync2_ff.flag_sel2, sync2_ff.flag_sel1_serial_enable_n,
                             sync2_ff.flag_sel0_serial_in};
  wire logic capture = !cfg_done_ff && (start_cnt_ff == FCP_CAPTURE_CYCLE);

  always_comb begin
    load_mode = FCP_LOAD_PRESET;
    preset_val = DEPTH_LOG2'(FCP_PRESET_64);
    case (fs_pat)
      FCP_FS_P16: preset_val = DEPTH_LOG2'(FCP_PRESET_16);
      FCP_FS_P8: preset_val = DEPTH_LOG2'(FCP_PRESET_8);
      FCP_FS_P256: preset_val = DEPTH_LOG2'(FCP_PRESET_256);
      FCP_FS_P1024: preset_val = DEPTH_LOG2'(FCP_PRESET_1024);
      FCP_FS_SERIAL: load_mode = FCP_LOAD_SERIAL;
      FCP_FS_PARALLEL: load_mode = FCP_LOAD_PARALLEL;
      FCP_FS_PAR_IP: load_mode = FCP_LOAD_PAR_IP;
      default: preset_val = DEPTH_LOG2'(FCP_PRESET_64);
    endcase
  end

  // Start-up counter, stops at the run point
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (!run_ff) begin
      start_cnt_ff <= start_cnt_ff + 3'h1;
      run_ff <= (start_cnt_ff + 3'h1) == FCP_RUN_CYCLE;
    end
  end

  // Latch configuration once the pins have settled
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_done_ff <= 1'b0;
      byte_order_ff <= 1'b0;
      fallthrough_mode_ff <= 1'b0;
      ip_ff <= 1'b0;
      par_ff <= 1'b0;
    end else if (capture) begin
      cfg_done_ff <= 1'b1;
      byte_order_ff <= sync2_ff.endian_mode_select;
      fallthrough_mode_ff <= !sync2_ff.endian_mode_select;
      ip_ff <= (load_mode == FCP_LOAD_PAR_IP);
      par_ff <= (load_mode == FCP_LOAD_PARALLEL);
    end
  end

  // ----------------------------------------------------------------
  // Offset unit
  // ----------------------------------------------------------------
  fcp_ofs_if #(.OFS_W(DEPTH_LOG2)) ofs_link ();

  fcp_offset_unit #(
    .OFS_W(DEPTH_LOG2)
  ) u_offset_unit (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .ofs(ofs_link.unit)
  );

  // ----------------------------------------------------------------
  // Memory and pointers
  // ----------------------------------------------------------------
  logic [FCP_DATA_W-1:0] mem [0:DEPTH-1];  // Word storage
  logic [DEPTH_LOG2-1:0] wr_ptr_ff;  // Next write slot
  logic [DEPTH_LOG2-1:0] rd_ptr_ff;  // Next read slot
  logic [CNT_W-1:0] cnt_ff;  // Words in memory
  logic [FCP_DATA_W-1:0] out_word_ff;  // Output register word
  logic out_valid_ff;  // Output register holds a popped word, cleared only by a fall-through drain
  logic [1:0] lane_ff;  // Lane currently shown
  logic [FCP_DATA_W-1:0] wr_echo_ff;  // Last word written to memory from the write port

  wire logic mem_empty = (cnt_ff == '0);
  wire logic mem_full = (cnt_ff == FULL_CNT);
  wire fcp_bus_size_t bus_size = fcp_bus_size_t'(sync2_ff.read_bus_size);
  wire logic [1:0] last_lane = (bus_size == FCP_BUS_BYTE) ? 2'h3 :
                               (bus_size == FCP_BUS_WORD) ? 2'h1 : 2'h0;
  wire logic lane_last = (lane_ff == last_lane);

  wire logic ir = run_ff && !mem_full &&
                  (ofs_link.done || ip_ff || par_ff);

  wire logic wr_req = cfg_done_ff && !sync2_ff.write_port_select_n &&
                      sync2_ff.write_port_direction && sync2_ff.write_port_enable &&
                      !sync2_ff.write_port_mailbox_sel && ir;
  wire logic mem_wr = wr_req && !ofs_link.absorb;

  // Read-side flag shown on the pin
  wire logic empty_output_ready = fallthrough_mode_ff ? out_valid_ff : !mem_empty;
  wire logic lanes_left = out_valid_ff && !lane_last;
  wire logic rd_flag = fallthrough_mode_ff ? out_valid_ff : (!mem_empty || lanes_left);
  wire logic rd_req = cfg_done_ff && !sync2_ff.read_port_select_n &&
                      sync2_ff.read_port_direction && sync2_ff.read_port_enable &&
                      !sync2_ff.read_port_mailbox_sel && rd_flag;
  wire logic advance = rd_req && lanes_left;
  // Standard loads only on a read
  wire logic pop = !mem_empty && (fallthrough_mode_ff ?
                   (!out_valid_ff || (rd_req && lane_last)) :
                   (rd_req && !lanes_left));
  wire logic drain = fallthrough_mode_ff && rd_req && lane_last && mem_empty;

  // Offset link drive
  assign ofs_link.capture = capture;
  assign ofs_link.mode = load_mode;
  assign ofs_link.preset = preset_val;
  assign ofs_link.par_wr = wr_req;
  assign ofs_link.par_data = sync2_ff.write_port_data;
  assign ofs_link.ser_bit = sync2_ff.flag_sel0_serial_in;
  assign ofs_link.ser_en_n = sync2_ff.flag_sel1_serial_enable_n;

  // Memory write, no reset on storage
  always_ff @(posedge i_sys_clk) begin
    if (mem_wr) begin
      mem[wr_ptr_ff] <= sync2_ff.write_port_data;
    end
  end

  // Pointers and word count
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + DEPTH_LOG2'(mem_wr);
      rd_ptr_ff <= rd_ptr_ff + DEPTH_LOG2'(pop);
      cnt_ff <= cnt_ff + CNT_W'(mem_wr) - CNT_W'(pop);
    end
  end

  // Output register and lane position
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_word_ff <= '0;
      out_valid_ff <= 1'b0;
      lane_ff <= '0;
    end else if (pop) begin
      out_word_ff <= mem[rd_ptr_ff];
      out_valid_ff <= 1'b1;
      lane_ff <= '0;
    end else if (advance) begin
      lane_ff <= lane_ff + 2'h1;
    end else if (drain) begin
      out_valid_ff <= 1'b0;
    end
  end

  // Write echo register for the write port outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_echo_ff <= '0;
    end else if (mem_wr) begin
      wr_echo_ff <= sync2_ff.write_port_data;
    end
  end

  // ----------------------------------------------------------------
  // Narrow lane selection
  // ----------------------------------------------------------------
  // Picks one lane; big order counts lanes from the top
  function automatic logic [FCP_DATA_W-1:0] lane_pick(
    input logic [FCP_DATA_W-1:0] word,
    input fcp_bus_size_t size,
    input logic [1:0] lane,
    input logic big
  );
    logic [1:0] idx;
    logic [FCP_DATA_W-1:0] res;
    idx = '0;
    res = word;
    case (size)
      FCP_BUS_WORD: begin
        idx = big ? (2'h1 - lane) : lane;
        res = FCP_DATA_W'(word[idx[0]*FCP_HALF_W +: FCP_HALF_W]);
      end
      FCP_BUS_BYTE: begin
        idx = big ? (2'h3 - lane) : lane;
        res = FCP_DATA_W'(word[idx*FCP_BYTE_W +: FCP_BYTE_W]);
      end
      default: res = word;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ordered narrow lanes
  assign o_read_port_data = lane_pick(out_word_ff, bus_size, lane_ff, byte_order_ff);
  assign o_read_port_data_oe = !i_read_port_select_n && i_read_port_direction;
  assign o_write_port_data_oe = !i_write_port_select_n && !i_write_port_direction;
  assign o_write_port_data = wr_echo_ff;

  assign o_full_input_ready = ir;
  assign o_empty_output_ready = empty_output_ready;
  assign o_almost_empty_n = !(cnt_ff <= CNT_W'(ofs_link.x_ofs));
  assign o_almost_full_n = !((FULL_CNT - cnt_ff) <= CNT_W'(ofs_link.y_ofs));

  assign o_byte_order_select = byte_order_ff;
  assign o_fallthrough_mode = fallthrough_mode_ff;
  assign o_interleaved_parity_mode = ip_ff;
  assign o_config_done = cfg_done_ff;

endmodule // fcp_port_access

// ==== test/fcp_port_access_chk.sv ====
`timescale 1ns/1ps
// -----------------------------
// Port access checker
// -----------------------------
module fcp_port_access_chk
  import fcp_pkg::*;
(
  input wire logic i_sys_clk, i_rst_n, i_write_port_select_n, i_write_port_direction,
  input wire logic i_read_port_select_n, i_read_port_direction, i_read_port_enable,
  input wire logic i_read_port_mailbox_sel, o_write_port_data_oe, o_read_port_data_oe,
  input wire logic o_full_input_ready, o_empty_output_ready, o_almost_empty_n,
  input wire logic o_almost_full_n, o_byte_order_select, o_fallthrough_mode, o_config_done,
  input wire logic [FCP_DATA_W-1:0] o_read_port_data
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Read requests seen at the pins over the last five edges
  wire rd_req = !i_read_port_select_n && i_read_port_direction && i_read_port_enable &&
    !i_read_port_mailbox_sel;
  logic [4:0] rd_hist_ff;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) rd_hist_ff <= 5'h0;
    else rd_hist_ff <= {rd_hist_ff[3:0], rd_req};
  end
  a_wr_oe_gate: assert property (o_write_port_data_oe ==
    (!i_write_port_select_n && !i_write_port_direction)) else $error("write oe wrong");
  a_rd_oe_gate: assert property (o_read_port_data_oe ==
    (!i_read_port_select_n && i_read_port_direction)) else $error("read oe wrong");
  a_reset_flags: assert property ($rose(i_rst_n) |-> !o_full_input_ready &&
    !o_empty_output_ready && !o_almost_empty_n && o_almost_full_n) else $error("reset flags");
  // Two sync edges plus two start-up edges pass before ready may rise
  a_ready_wait: assert property ($rose(i_rst_n) |->
    !o_full_input_ready[*4]) else $error("ready too early");
  a_cfg_hold: assert property (o_config_done |=>
    $stable({o_byte_order_select, o_fallthrough_mode})) else $error("config moved");
  a_std_read: assert property (o_config_done && !o_fallthrough_mode &&
    $changed(o_read_port_data) |-> |rd_hist_ff) else $error("data moved unread");
  a_empty_ae: assert property (o_config_done && !o_fallthrough_mode &&
    !o_empty_output_ready |-> !o_almost_empty_n) else $error("empty not almost empty");
  a_idle_flags: assert property (!o_config_done |->
    !o_full_input_ready && !o_empty_output_ready) else $error("flags before config");
  c_std_data: cover property (!o_fallthrough_mode && $rose(o_empty_output_ready));
  c_fall_data: cover property (o_fallthrough_mode && $rose(o_empty_output_ready));
  c_ready: cover property ($rose(o_full_input_ready));
endmodule // fcp_port_access_chk

bind fcp_port_access fcp_port_access_chk u_chk (.*);

// ==== test/fcp_far_model.sv ====
`timescale 1ns/1ps
// -----------------------------
// Far-side port master
// -----------------------------
module fcp_far_model (
  input wire logic i_clk,
  output logic o_ws_n, o_wdir, o_we, o_rs_n, o_rdir, o_re,
  output logic [35:0] o_wdat
);
  // Idle: both ports deselected, write port set to write
  initial {o_ws_n, o_wdir, o_we, o_rs_n, o_rdir, o_re, o_wdat} = {6'h36, 36'h0};
  // One write held one cycle; released data lines show the inverse
  task automatic wr(input logic [35:0] d);
    @(negedge i_clk) {o_ws_n, o_we, o_wdat} = {2'h1, d};
    @(negedge i_clk) {o_ws_n, o_we, o_wdat} = {2'h2, ~d};
  endtask
  // One read; the write port is turned round to drive meanwhile
  task automatic rd();
    @(negedge i_clk) {o_rs_n, o_re, o_ws_n, o_wdir} = 4'h4;
    @(negedge i_clk) {o_rs_n, o_re, o_ws_n, o_wdir} = 4'hb;
  endtask
endmodule // fcp_far_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
// -----------------------------
// Port access bench
// -----------------------------
module tb;
  import fcp_pkg::*;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
  logic clk = 0, rst_n = 0, ems = 1, fs2 = 1, fs1 = 1, fs0 = 1;
  logic [1:0] bsz = 2'h0;
  logic ws_n, wdir, we, rs_n, rdir, re, woe, roe, ff, ef, ae_n, af_n, bo, ft, ip, done;
  logic [35:0] wdat, wout, rout;
  int miscompares = 0, check_count = 0;
  fcp_far_model far (.i_clk(clk), .o_ws_n(ws_n), .o_wdir(wdir), .o_we(we), .o_rs_n(rs_n),
    .o_rdir(rdir), .o_re(re), .o_wdat(wdat));
  fcp_port_access uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_endian_mode_select(ems),
    .i_flag_sel2(fs2), .i_flag_sel1_serial_enable_n(fs1), .i_flag_sel0_serial_in(fs0),
    .i_read_bus_size(bsz), .i_write_port_select_n(ws_n), .i_write_port_direction(wdir),
    .i_write_port_enable(we), .i_write_port_mailbox_sel(1'b0),
    .i_write_port_data(woe ? wout : wdat), .o_write_port_data(wout),
    .o_write_port_data_oe(woe), .i_read_port_select_n(rs_n), .i_read_port_direction(rdir),
    .i_read_port_enable(re), .i_read_port_mailbox_sel(1'b0), .o_read_port_data(rout),
    .o_read_port_data_oe(roe), .o_full_input_ready(ff), .o_empty_output_ready(ef),
    .o_almost_empty_n(ae_n), .o_almost_full_n(af_n), .o_byte_order_select(bo),
    .o_fallthrough_mode(ft), .o_interleaved_parity_mode(ip), .o_config_done(done));
  initial forever #20 clk = ~clk;
  // Verdict and end of run
  task automatic results();
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reset with mode pin, flag selects and bus size, then wait out start-up
  task automatic rst(input logic m, input logic [2:0] fs, input logic [1:0] sz);
    @(negedge clk) {rst_n, ems, fs2, fs1, fs0, bsz} = {1'b0, m, fs, sz};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // Bounded wait for a flag to go high
  task automatic wait_hi(ref logic s);
    int n;
    for (n = 0; s !== 1'b1 && n < 60; n++) @(negedge clk);
    if (n == 60) begin
      miscompares++;
      $display("[ERR] %0t wait ran out", $time);
      results();
    end
  endtask
  // Write n words, let flags settle, judge almost-empty
  task automatic wr_ae(input int n, input logic e);
    repeat (n) far.wr(36'h0);
    repeat (6) @(negedge clk);
    `CHK(ae_n, e)
  endtask
  // Preset offsets in standard mode
  task automatic t_preset(input logic [2:0] fs, input int x);
    rst(1'b1, fs, 2'h0);
    `CHK({ff, ft, done, af_n}, 4'hb)
    wr_ae(x, 1'b0);
    wr_ae(1, 1'b1);
  endtask
  // Big byte order: top lane first, nothing moves before a read
  task automatic t_bytes();
    logic [35:0] w;
    w = 36'h1_2345_6789;
    rst(1'b1, FCP_FS_P8, 2'h2);
    `CHK(bo, 1'b1)
    far.wr(w);
    wait_hi(ef);
    `CHK(wout, w)
    `CHK({woe, roe}, 2'h0)
    `CHK(rout, 36'h0)
    for (int i = 3; i >= 0; i--) begin
      far.rd();
      repeat (4) @(negedge clk);
      `CHK(rout, {27'h0, w[i*9 +: 9]})
    end
  endtask
  // Offsets from the write port, then the first word falls through
  task automatic t_parallel(input logic ip_on);
    logic [35:0] w;
    w = 36'h5_a5a5_a5a5;
    rst(1'b0, ip_on ? FCP_FS_PAR_IP : FCP_FS_PARALLEL, {1'b0, ip_on});
    `CHK({ip, ft}, {ip_on, 1'b1})
    far.wr(36'h3);
    far.wr(ip_on ? 36'h102 : 36'h2);
    far.wr(w);
    wait_hi(ef);
    `CHK(rout, ip_on ? {18'h0, w[17:0]} : w)
    // Word lanes, little order: low half first, then the high half
    if (ip_on) begin
      far.rd();
      repeat (4) @(negedge clk);
      `CHK(rout, {18'h0, w[35:18]})
    end
    wr_ae(3, 1'b1);
  endtask
  // Serial offsets Y=5 then X=1, top bit first
  task automatic t_serial();
    logic [27:0] b;
    b = {14'h5, 14'h1};
    rst(1'b1, FCP_FS_SERIAL, 2'h0);
    for (int i = 27; i >= 0; i--) begin
      @(negedge clk) {fs1, fs0} = {1'b0, b[i]};
      `CHK(ff, 1'b0)
    end
    @(negedge clk) fs1 = 1'b1;
    wait_hi(ff);
    wr_ae(1, 1'b0);
    wr_ae(1, 1'b1);
  endtask
  // Main sequence
  initial begin
    t_preset(FCP_FS_P64, FCP_PRESET_64);
    t_preset(FCP_FS_P16, FCP_PRESET_16);
    t_preset(FCP_FS_P8, FCP_PRESET_8);
    t_preset(FCP_FS_P256, FCP_PRESET_256);
    t_preset(FCP_FS_P1024, FCP_PRESET_1024);
    t_bytes();
    t_parallel(1'b0);
    t_parallel(1'b1);
    t_serial();
    results();
  end
endmodule // tb
